/* design/spi_special.sv */
`timescale 1ns/1ps
module spi_special #(
  parameter int HALF_DIV = spi_special_pkg::HALF_DIV_DEFAULT
) (
  input  wire logic                                   clk,
  input  wire logic                                   resetn,
  input  wire logic                                   ce,
  input  wire logic                                   serial_clock_in,
  input  wire logic                                   select_in,
  input  wire logic                                   mosi_in,
  input  wire logic                                   miso_in,
  input  wire logic                                   cpu_wait,
  input  wire logic                                   stop_retain,
  input  wire logic                                   stop_lost,
  input  wire logic                                   ctrl1_write,
  input  wire spi_special_pkg::ctrl1_s                ctrl1_wdata,
  input  wire logic                                   ctrl2_write,
  input  wire spi_special_pkg::ctrl2_s                ctrl2_wdata,
  input  wire logic                                   status_read,
  input  wire logic                                   data_read,
  input  wire logic                                   data_write,
  input  wire logic [spi_special_pkg::WORD_MAX-1:0]   data_wdata,
  input  wire logic [spi_special_pkg::WORD_MAX-1:0]   match_value,
  output spi_special_pkg::ctrl1_s                     ctrl1,
  output spi_special_pkg::ctrl2_s                     ctrl2,
  output spi_special_pkg::status_s                    status,
  output logic [spi_special_pkg::WORD_MAX-1:0]        data_register,
  output logic                                        irq,
  output logic                                        serial_clock_out,
  output logic                                        serial_clock_oe_n,
  output logic                                        mosi_out,
  output logic                                        mosi_oe_n,
  output logic                                        miso_out,
  output logic                                        miso_oe_n,
  output logic                                        select_out,
  output logic                                        select_oe_n
);
  import spi_special_pkg::*;

  localparam int DIV_W = $clog2(HALF_DIV + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(HALF_DIV - 1);

  generate
    if (HALF_DIV < HALF_DIV_MIN) begin : g_bad_div
      $error("HALF_DIV too small for the data input synchroniser");
    end
  endgenerate

  typedef struct packed {
    ctrl1_s              c1;
    ctrl2_s              c2;
    status_s             st;
    logic [WORD_MAX-1:0] rx_data;
    logic [WORD_MAX-1:0] tx_buf;
    logic [WORD_MAX-1:0] shreg;
    logic                tx_full;
    logic                tx_req;
    logic [CNT_W-1:0]    bitcnt;
    logic [DIV_W-1:0]    div;
    master_state_e       mst;
    logic                sampled;
    logic [SYNC_W-1:0]   ss_sync;
    logic [SYNC_W-1:0]   mi_sync;
    logic [SYNC_W-1:0]   ack_sync;
    logic [SYNC_W:0]     rx_sync;
    logic                arm_rx;
    logic                arm_tx;
    logic                arm_mf;
    logic                sck_out;
    logic                sck_oe_n;
    logic                mosi_out;
    logic                mosi_oe_n;
    logic                miso_oe_n;
    logic                sel_out;
    logic                sel_oe_n;
    logic                irq;
  } core_s;

  typedef struct packed {
    logic [WORD_MAX-1:0] shreg;
    logic [WORD_MAX-1:0] rx_word;
    logic [CNT_W-1:0]    cnt;
    logic                sout;
    logic                rx_tog;
    logic                ack;
    logic [SYNC_W-1:0]   req_sync;
    logic [SYNC_W-1:0]   len_sync;
    logic [SYNC_W-1:0]   sw_sync;
  } link_s;

  core_s core;
  core_s next_core;
  link_s link;
  link_s next_link;
  logic  hold;
  logic  fault;

  function automatic core_s core_reset();
    core_s r;
    r           = '0;
    r.c1        = CTRL1_RESET;
    r.c2        = CTRL2_RESET;
    r.st        = STATUS_RESET;
    r.rx_data   = DATA_RESET;
    r.mst       = M_IDLE;
    r.ss_sync   = 2'h3;
    r.sel_out   = 1'b1;
    r.sck_oe_n  = 1'b1;
    r.mosi_oe_n = 1'b1;
    r.miso_oe_n = 1'b1;
    r.sel_oe_n  = 1'b1;
    return r;
  endfunction

  // completed word into the data register; a word arriving while the
  // previous one is unread is dropped whole
  function automatic core_s take_word(core_s s, logic [WORD_MAX-1:0] w);
    core_s r;
    logic [WORD_MAX-1:0] word;
    logic [WORD_MAX-1:0] cmp;
    r    = s;
    word = s.c2.data_16bit ? w : {8'h00, w[WORD_SHORT-1:0]};
    cmp  = s.c2.data_16bit ? match_value : {8'h00, match_value[WORD_SHORT-1:0]};
    if (!s.st.receive_full_flag) begin
      r.rx_data              = word;
      r.st.receive_full_flag = 1'b1;
      if (word == cmp) begin
        r.st.match_flag = 1'b1;
      end
    end
    return r;
  endfunction

  // bus clock frozen by clock enable, retained stop, or wait with stop_in_wait
  assign hold = stop_retain || (cpu_wait && core.c2.stop_in_wait);

  assign fault = core.c1.module_enable && core.c1.master_select && core.c2.fault_detect_enable
              && !core.c1.select_output_enable && !core.ss_sync[1];

  always_comb begin
    logic [3:0]          msb;
    logic [CNT_W-1:0]    last;
    logic [WORD_MAX-1:0] shifted;
    logic                master;
    logic                slave;
    next_core = core;
    msb       = core.c2.data_16bit ? MSB_LONG : MSB_SHORT;
    last      = core.c2.data_16bit ? LAST_LONG : LAST_SHORT;
    shifted   = {core.shreg[WORD_MAX-2:0], core.sampled};
    master    = 1'b0;
    slave     = 1'b0;

    next_core.ss_sync  = {core.ss_sync[0], select_in};
    next_core.mi_sync  = {core.mi_sync[0], core.c2.single_wire_select ? mosi_in : miso_in};
    next_core.ack_sync = {core.ack_sync[0], link.ack};
    next_core.rx_sync  = {core.rx_sync[SYNC_W-1:0], link.rx_tog};

    if (ctrl1_write) begin
      next_core.c1 = ctrl1_wdata;
    end
    if (ctrl2_write) begin
      next_core.c2 = ctrl2_wdata;
    end

    // flag clears need a status read with the flag set first
    if (status_read) begin
      next_core.arm_rx = core.st.receive_full_flag;
      next_core.arm_tx = core.st.transmit_empty_flag;
      next_core.arm_mf = core.st.mode_fault_flag;
    end
    if (data_read && core.arm_rx) begin
      next_core.st.receive_full_flag = 1'b0;
      next_core.st.match_flag        = 1'b0;
      next_core.arm_rx               = 1'b0;
    end
    if (ctrl1_write && core.arm_mf) begin
      next_core.st.mode_fault_flag = 1'b0;
      next_core.arm_mf             = 1'b0;
    end
    if (data_write && core.arm_tx) begin
      next_core.st.transmit_empty_flag = 1'b0;
      next_core.arm_tx                 = 1'b0;
    end
    if (data_write && !core.tx_full) begin
      next_core.tx_buf  = core.c2.data_16bit ? data_wdata : {8'h00, data_wdata[WORD_SHORT-1:0]};
      next_core.tx_full = 1'b1;
      if (!core.c1.master_select) begin
        next_core.tx_req = ~core.tx_req;
      end
    end

    // slave side: link took the buffer, or finished a word
    if (core.tx_full && !core.c1.master_select && core.ack_sync[1] == core.tx_req) begin
      next_core.tx_full                = 1'b0;
      next_core.st.transmit_empty_flag = 1'b1;
    end
    // link also clocks on our own serial clock as master; only a slave takes its words
    if (core.rx_sync[SYNC_W] != core.rx_sync[SYNC_W-1] && core.c1.module_enable && !core.c1.master_select) begin
      next_core = take_word(next_core, link.rx_word);
    end

    if (fault) begin
      next_core.st.mode_fault_flag = 1'b1;
      next_core.c1.master_select   = 1'b0;
      if (core.c2.single_wire_select) begin
        next_core.c2.single_wire_output_enable = 1'b0;
      end
    end

    if (fault || !core.c1.module_enable || !core.c1.master_select) begin
      next_core.mst     = M_IDLE;
      next_core.sck_out = 1'b0;
      next_core.sel_out = 1'b1;
      next_core.div     = '0;
    end else begin
      case (core.mst)
        M_IDLE: begin
          if (core.tx_full) begin
            next_core.shreg                  = core.tx_buf;
            next_core.tx_full                = 1'b0;
            next_core.st.transmit_empty_flag = 1'b1;
            next_core.bitcnt                 = '0;
            next_core.div                    = '0;
            next_core.sel_out                = 1'b0;
            next_core.mosi_out               = core.tx_buf[msb];
            next_core.mst                    = M_LOW;
          end
        end
        M_LOW: begin
          if (core.div == DIV_LAST) begin
            next_core.div     = '0;
            next_core.sck_out = 1'b1;
            next_core.sampled = core.mi_sync[1];
            next_core.mst     = M_HIGH;
          end else begin
            next_core.div = core.div + 1'b1;
          end
        end
        M_HIGH: begin
          if (core.div == DIV_LAST) begin
            next_core.div     = '0;
            next_core.sck_out = 1'b0;
            next_core.shreg   = shifted;
            if (core.bitcnt == last) begin
              next_core         = take_word(next_core, shifted);
              next_core.sel_out = 1'b1;
              next_core.mst     = M_IDLE;
            end else begin
              next_core.bitcnt   = core.bitcnt + 1'b1;
              next_core.mosi_out = shifted[msb];
              next_core.mst      = M_LOW;
            end
          end else begin
            next_core.div = core.div + 1'b1;
          end
        end
        default: begin
          next_core.mst = M_IDLE;
        end
      endcase
    end

    master = next_core.c1.module_enable && next_core.c1.master_select;
    slave  = next_core.c1.module_enable && !next_core.c1.master_select && !next_core.st.mode_fault_flag;
    next_core.sck_oe_n  = !master;
    next_core.mosi_oe_n = !(master && (!next_core.c2.single_wire_select
                          || next_core.c2.single_wire_output_enable));
    next_core.miso_oe_n = !(slave && !core.ss_sync[1] && (!next_core.c2.single_wire_select
                          || next_core.c2.single_wire_output_enable));
    next_core.sel_oe_n  = !(master && next_core.c2.fault_detect_enable
                          && next_core.c1.select_output_enable);

    next_core.irq = next_core.c1.module_enable && (
      (next_core.c1.rx_fault_irq_enable && (next_core.st.receive_full_flag
        || next_core.st.mode_fault_flag))
      || (next_core.c1.transmit_irq_enable && next_core.st.transmit_empty_flag)
      || (next_core.c2.match_irq_enable && next_core.st.match_flag));
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      core <= core_reset();
    end else if (ce) begin
      if (stop_lost) begin
        core <= core_reset();
      end else if (!hold) begin
        core <= next_core;
      end
    end
  end

  // link side, clocked by the external master's serial clock; it keeps
  // shifting while the bus clock is held, so the slave stays in step
  always_comb begin
    logic [3:0]          msb;
    logic [CNT_W-1:0]    last;
    logic [WORD_MAX-1:0] shifted;
    logic                din;
    next_link          = link;
    next_link.req_sync = {link.req_sync[0], core.tx_req};
    next_link.len_sync = {link.len_sync[0], core.c2.data_16bit};
    next_link.sw_sync  = {link.sw_sync[0], core.c2.single_wire_select};
    msb                = link.len_sync[1] ? MSB_LONG : MSB_SHORT;
    last               = link.len_sync[1] ? LAST_LONG : LAST_SHORT;
    din                = link.sw_sync[1] ? miso_in : mosi_in;
    shifted            = {link.shreg[WORD_MAX-2:0], din};
    if (link.cnt == last) begin
      next_link.cnt     = '0;
      next_link.rx_word = shifted;
      next_link.rx_tog  = ~link.rx_tog;
      // tx_buf is stable while the request is open, so it is read directly
      if (link.req_sync[1] != link.ack) begin
        next_link.shreg = core.tx_buf;
        next_link.ack   = link.req_sync[1];
      end else begin
        next_link.shreg = shifted;
      end
      next_link.sout = next_link.shreg[msb];
    end else begin
      next_link.cnt   = link.cnt + 1'b1;
      next_link.shreg = shifted;
      next_link.sout  = shifted[msb];
    end
  end

  // output bit changes on the sampling edge; fine at the rates this serves
  always_ff @(posedge serial_clock_in or negedge resetn) begin
    if (!resetn) begin
      link <= '0;
    end else if (!select_in) begin
      link <= next_link;
    end
  end

  assign ctrl1             = core.c1;
  assign ctrl2             = core.c2;
  assign status            = core.st;
  assign data_register     = core.rx_data;
  assign irq               = core.irq;
  assign serial_clock_out  = core.sck_out;
  assign serial_clock_oe_n = core.sck_oe_n;
  assign mosi_out          = core.mosi_out;
  assign mosi_oe_n         = core.mosi_oe_n;
  assign miso_out          = link.sout;
  assign miso_oe_n         = core.miso_oe_n;
  assign select_out        = core.sel_out;
  assign select_oe_n       = core.sel_oe_n;

  sel_low_a: assert property (@(posedge clk) disable iff (!resetn)
    core.mst != M_IDLE |-> !core.sel_out)
    else $error("select high during a master transfer");

  fault_gate_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(core.st.mode_fault_flag) |-> $past(!core.c1.select_output_enable && core.c2.fault_detect_enable))
    else $error("mode fault raised while detection was off");

  single_dir_a: assert property (@(posedge clk) disable iff (!resetn)
    core.c2.single_wire_select && !core.c2.single_wire_output_enable |-> core.mosi_oe_n && core.miso_oe_n)
    else $error("single wire pin driven with output enable clear");

  sck_dir_a: assert property (@(posedge clk) disable iff (!resetn)
    !core.sck_oe_n |-> core.c1.master_select && core.c1.module_enable)
    else $error("serial clock driven outside master mode");

  fault_set_a: assert property (@(posedge clk) disable iff (!resetn)
    ce && !hold && !stop_lost && fault |=> core.st.mode_fault_flag && !core.c1.master_select)
    else $error("low select in master mode did not raise a fault");

  fault_abort_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(core.st.mode_fault_flag) |-> core.mst == M_IDLE && core.sck_oe_n && core.mosi_oe_n && core.miso_oe_n)
    else $error("mode fault left the pins driven");

  fault_clear_a: assert property (@(posedge clk) disable iff (!resetn)
    $fell(core.st.mode_fault_flag) && !$past(stop_lost) |-> $past(ctrl1_write && core.arm_mf))
    else $error("mode fault cleared without read then write");

  irq_enable_a: assert property (@(posedge clk) disable iff (!resetn)
    core.irq |-> core.c1.module_enable)
    else $error("interrupt while module disabled");

  fault_irq_a: assert property (@(posedge clk) disable iff (!resetn)
    core.st.mode_fault_flag && core.c1.rx_fault_irq_enable && core.c1.module_enable |-> core.irq)
    else $error("mode fault interrupt dropped while flag set");

  rx_keep_a: assert property (@(posedge clk) disable iff (!resetn)
    $past(core.st.receive_full_flag) && core.st.receive_full_flag |-> $stable(core.rx_data))
    else $error("unread data overwritten");

  master_rx_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(core.st.receive_full_flag) && $past(core.c1.master_select) |-> $past(core.mst == M_HIGH))
    else $error("master took a word outside its own shift");

  match_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(core.st.match_flag) |-> core.rx_data[WORD_SHORT-1:0] == match_value[WORD_SHORT-1:0])
    else $error("match flag without equal data");

  master_word_c: cover property (@(posedge clk) disable iff (!resetn)
    core.mst == M_HIGH ##1 core.mst == M_IDLE ##1 core.st.receive_full_flag);

  mode_fault_c: cover property (@(posedge clk) disable iff (!resetn)
    $rose(core.st.mode_fault_flag));

  slave_word_c: cover property (@(posedge clk) disable iff (!resetn)
    !core.c1.master_select && $rose(core.st.receive_full_flag));

endmodule

/* design/spi_special_pkg.sv */
package spi_special_pkg;

  localparam int WORD_MAX   = 16;
  localparam int WORD_SHORT = 8;
  localparam int CNT_W      = 5;
  localparam int SYNC_W     = 2;

  // master half bit period in bus clocks, smallest the pin synchroniser allows
  localparam int HALF_DIV_DEFAULT = 4;
  localparam int HALF_DIV_MIN     = 4;

  localparam logic [3:0] MSB_LONG  = 4'hf;
  localparam logic [3:0] MSB_SHORT = 4'h7;
  localparam logic [CNT_W-1:0] LAST_LONG  = 5'h0f;
  localparam logic [CNT_W-1:0] LAST_SHORT = 5'h07;

  typedef struct packed {
    logic rx_fault_irq_enable;
    logic module_enable;
    logic transmit_irq_enable;
    logic master_select;
    logic select_output_enable;
  } ctrl1_s;

  typedef struct packed {
    logic match_irq_enable;
    logic data_16bit;
    logic fault_detect_enable;
    logic single_wire_output_enable;
    logic stop_in_wait;
    logic single_wire_select;
  } ctrl2_s;

  typedef struct packed {
    logic receive_full_flag;
    logic match_flag;
    logic transmit_empty_flag;
    logic mode_fault_flag;
  } status_s;

  localparam ctrl1_s  CTRL1_RESET  = 5'h00;
  localparam ctrl2_s  CTRL2_RESET  = 6'h00;
  localparam status_s STATUS_RESET = 4'h2;
  localparam logic [WORD_MAX-1:0] DATA_RESET = 16'h0000;

  typedef enum logic [2:0] {
    M_IDLE = 3'b001,
    M_LOW  = 3'b010,
    M_HIGH = 3'b100
  } master_state_e;

endpackage

/* testbench/spi_far_end.sv */
`timescale 1ns/1ps
module spi_far_end (
  input  wire logic        clk_link,
  input  wire logic        act_master,
  input  wire logic        sck_pin,
  input  wire logic        ss_pin,
  input  wire logic        mosi_pin,
  input  wire logic        miso_pin,
  output logic             sck_drv,
  output logic             ss_drv,
  output logic             mosi_drv,
  output logic             mosi_en,
  output logic             miso_drv,
  output logic [15:0]      rx_word
);
  logic [15:0] sh = 16'h0000;
  initial begin
    sck_drv = 1'b0;
    ss_drv = 1'b1;
    mosi_en = 1'b0;
    rx_word = 16'h0000;
  end
  assign mosi_drv = sh[15];
  assign miso_drv = sh[15];
  task automatic prime(input logic [15:0] v);
    sh = v;
  endtask
  // as slave: sample on rise, next bit on fall
  always @(posedge sck_pin)
    if (!act_master && !ss_pin) rx_word <= {rx_word[14:0], mosi_pin};
  always @(negedge sck_pin)
    if (!act_master && !ss_pin) sh <= sh << 1;
  // as master: clock only inside the frame, select released between frames
  task automatic frame(input logic [15:0] v, input int n);
    sh = v;
    @(posedge clk_link);
    ss_drv = 1'b0;
    mosi_en = 1'b1;
    repeat (n) begin
      @(posedge clk_link);
      rx_word = {rx_word[14:0], miso_pin};
      sck_drv = 1'b1;
      @(negedge clk_link);
      sck_drv = 1'b0;
      sh = sh << 1;
    end
    @(posedge clk_link);
    ss_drv = 1'b1;
    mosi_en = 1'b0;
    repeat (3) @(posedge clk_link);
  endtask
endmodule

/* testbench/tb.sv */
`timescale 1ns/1ps
module tb;
  import spi_special_pkg::*;
  localparam logic [4:0] C1 = 5'h10;
  localparam logic [4:0] SR = 5'h04;
  localparam logic [4:0] DR = 5'h02;
  localparam logic [4:0] DW = 5'h01;
  logic          clk, clk_link, resetn, cpu_wait, stop_retain, stop_lost, ss_tb, noise, far_m;
  logic          c1w, c2w, srd, drd, dwr, irq, sck_o, sck_n, mosi_o, mosi_n, miso_o, miso_n, ss_o, ss_n;
  logic          f_sck, f_ss, f_mosi, f_mosi_en, f_miso;
  ctrl1_s        c1d, ctrl1;
  ctrl2_s        c2d, ctrl2;
  status_s       status;
  logic [15:0]   dwd, mval, data_register, w, fw, f_rx;
  logic [15:0]   exp_q[$];
  wire logic     sck_l, ss_l, mosi_l, miso_l;
  int            bad_count, checks_done, hi_edges, edges;
  // undriven data lines toggle so a stale bit cannot pass
  assign sck_l = !sck_n ? sck_o : (far_m & f_sck);
  assign ss_l = ss_tb & (!ss_n ? ss_o : (!far_m | f_ss));
  assign mosi_l = !mosi_n ? mosi_o : (far_m & f_mosi_en ? f_mosi : noise);
  assign miso_l = !miso_n ? miso_o : (!far_m & !ss_l ? f_miso : noise);
  spi_special #(.HALF_DIV(4)) u_spi_special (
    .clk(clk), .resetn(resetn), .ce(1'b1), .serial_clock_in(sck_l), .select_in(ss_l), .mosi_in(mosi_l),
    .miso_in(miso_l), .cpu_wait(cpu_wait), .stop_retain(stop_retain), .stop_lost(stop_lost),
    .ctrl1_write(c1w), .ctrl1_wdata(c1d), .ctrl2_write(c2w), .ctrl2_wdata(c2d), .status_read(srd),
    .data_read(drd), .data_write(dwr), .data_wdata(dwd), .match_value(mval), .ctrl1(ctrl1),
    .ctrl2(ctrl2), .status(status), .data_register(data_register), .irq(irq), .serial_clock_out(sck_o),
    .serial_clock_oe_n(sck_n), .mosi_out(mosi_o), .mosi_oe_n(mosi_n), .miso_out(miso_o),
    .miso_oe_n(miso_n), .select_out(ss_o), .select_oe_n(ss_n));
  spi_far_end u_far (.clk_link(clk_link), .act_master(far_m), .sck_pin(sck_l), .ss_pin(ss_l),
    .mosi_pin(mosi_l), .miso_pin(miso_l), .sck_drv(f_sck), .ss_drv(f_ss), .mosi_drv(f_mosi),
    .mosi_en(f_mosi_en), .miso_drv(f_miso), .rx_word(f_rx));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    clk_link = 1'b0;
    #7;
    forever #15 clk_link = ~clk_link;
  end
  always @(posedge clk) noise <= ~noise;
  always @(posedge sck_l) begin
    edges++;
    if (ss_l && !far_m) hi_edges++;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic hit(input logic [4:0] s);
    @(posedge clk);
    {c1w, c2w, srd, drd, dwr} <= s;
    @(posedge clk);
    {c1w, c2w, srd, drd, dwr} <= 5'h00;
    #1;
  endtask
  task automatic set_regs(input logic [4:0] a, input logic [5:0] b);
    c1d <= a;
    c2d <= b;
    hit(5'h08);
    hit(C1);
  endtask
  // pause 1 = wait with stop_in_wait, 2 = retained stop; clock must freeze
  task automatic wait_rf(input int pause);
    int k;
    int e0;
    k = 0;
    e0 = 0;
    while (status.receive_full_flag !== 1'b1 && k < 400) begin
      cyc(1);
      k++;
      if (k == 10) begin
        cpu_wait <= (pause == 1);
        stop_retain <= (pause == 2);
      end
      if (k == 14) e0 = edges;
      if (k == 50) begin
        if (pause != 0) chk(16'(edges - e0), 16'h0000);
        cpu_wait <= 1'b0;
        stop_retain <= 1'b0;
      end
    end
    chk(16'(status.receive_full_flag), 16'h0001);
  endtask
  task automatic mxfer(input int n);
    logic [15:0] m;
    m = (n == 8) ? 16'h00ff : 16'hffff;
    w = $urandom;
    fw = $urandom;
    mval <= (n == 8) ? {~fw[15:8], fw[7:0]} : fw ^ 16'h0100;
    exp_q.push_back(fw & m);
    u_far.prime(n == 8 ? {fw[7:0], 8'h00} : fw);
    dwd <= w;
    hit(SR);
    hit(DW);
    wait_rf(n == 8 ? 2 : 1);
    cyc(2);
    chk(data_register, exp_q.pop_front());
    chk(f_rx & m, w & m);
    chk(16'({status, irq}), n == 8 ? 16'h001d : 16'h0014);
    chk(16'(hi_edges), 16'h0000);
    chk(16'(ss_l), 16'h0001);
    hit(SR);
    hit(DR);
    chk(16'({status.receive_full_flag, status.match_flag}), 16'h0000);
  endtask
  task automatic report_and_stop();
    if (bad_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #500000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'h2be3));
    {resetn, cpu_wait, stop_retain, stop_lost, noise, far_m, c1w, c2w, srd, drd, dwr} = 11'h000;
    {c1d, c2d, dwd, mval} = 43'h0;
    ss_tb = 1'b1;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    cyc(1);
    chk(16'({status, irq, sck_n, mosi_n, miso_n, ss_n}), 16'({STATUS_RESET, 5'h0f}));
    chk(data_register, 16'h0000);
    set_regs(5'h04, 6'h00);
    cyc(2);
    chk(16'({ctrl1, irq}), 16'h0008);
    c1d <= 5'h0c;
    hit(C1);
    cyc(2);
    chk(16'(irq), 16'h0001);
    c1d <= 5'h08;
    hit(C1);
    cyc(2);
    chk(16'(irq), 16'h0000);
    for (int n = 8; n <= 16; n += 8) begin
      set_regs(5'h0b, n == 8 ? 6'h2a : 6'h1a);
      mxfer(n);
    end
    // select low must not fault: once with select output on, once detection off
    for (int i = 0; i < 2; i++) begin
      set_regs(i == 0 ? 5'h0b : 5'h1a, i == 0 ? 6'h0a : 6'h00);
      ss_tb <= 1'b0;
      cyc(5);
      chk(16'({status.mode_fault_flag, ctrl1.master_select}), 16'h0001);
      ss_tb <= 1'b1;
      cyc(3);
    end
    set_regs(5'h1a, 6'h0d);
    chk(16'({sck_n, mosi_n, miso_n}), 16'h0001);
    ss_tb <= 1'b0;
    cyc(5);
    chk(16'({status.mode_fault_flag, ctrl1.master_select, ctrl2.single_wire_output_enable}), 16'h0004);
    chk(16'({sck_n, mosi_n, miso_n, irq}), 16'h000f);
    ss_tb <= 1'b1;
    cyc(3);
    hit(SR);
    hit(C1);
    cyc(2);
    chk(16'({status.mode_fault_flag, irq, ctrl1.master_select}), 16'h0001);
    far_m = 1'b1;
    set_regs(5'h18, 6'h10);
    w = $urandom;
    dwd <= w;
    hit(SR);
    hit(DW);
    fw = $urandom;
    u_far.frame(fw, 16);
    wait_rf(0);
    cyc(2);
    chk(data_register, fw);
    chk(16'(irq), 16'h0001);
    u_far.frame(~fw, 16);
    cyc(8);
    chk(f_rx, w);
    chk(data_register, fw);
    stop_lost <= 1'b1;
    cyc(3);
    stop_lost <= 1'b0;
    cyc(1);
    chk(16'({ctrl1, ctrl2, status}), 16'({CTRL1_RESET, CTRL2_RESET, STATUS_RESET}));
    chk(data_register, DATA_RESET);
    report_and_stop();
  end
endmodule
